// file: cc_retrain_sequencer.sv
// Behaviour
// - on request drop cts, send ac
// - receiver detects pph during retrain
// - raise cts again when retrain completes
// - repeat mph until two identical received
// - accept alt lasting 16t to 120t
// - data mode reports 84 in both
// - retrain: tx 8a sending ac, rx 86
// - no change pages: 80, 87, 89 codes
// - low five bits hold phase state
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "retrain_cfg.svh"

module cc_retrain_sequencer
  import retrain_pkg::*;
#(
  parameter int          SYMBOL_CYCLES = 16,                  // clocks per symbol t
  parameter int unsigned TIMEOUT_CYCLES = `STEP_TIMEOUT_CYC   // per-step limit
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ac_detect,      // receiver sees ac
  input  wire logic        pph_detect,     // receiver sees pph
  input  wire logic        alt_detect,     // receiver sees alt, level
  input  wire logic        mph_match,      // two identical mph frames in
  input  wire logic        e_detect,       // receiver sees e sequence
  input  wire logic        sh_detect,      // receiver sees sh
  output logic             cts,
  output tx_signal_type    tx_signal,
  output logic             irq
);

  localparam int unsigned ALT_MIN_CYC = `ALT_MIN_SYM * SYMBOL_CYCLES;
  localparam int unsigned ALT_MAX_CYC = `ALT_MAX_SYM * SYMBOL_CYCLES;

  // synchronised line events
  logic [5:0] ev;
  line_event_sync #(.WIDTH(6)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({sh_detect, e_detect, mph_match, alt_detect, pph_detect, ac_detect}),
    .sync_out (ev)
  );
  logic ev_ac, ev_pph, ev_alt, ev_mph2, ev_e, ev_sh;
  assign {ev_sh, ev_e, ev_mph2, ev_alt, ev_pph, ev_ac} = ev;

  // apb decode
  logic wr_acc;   // write access phase
  logic rd_acc;   // read access phase
  logic mapped;   // address hits a register
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = (paddr == `OFS_CONTROL) || (paddr == `OFS_STATUS) ||
                  (paddr == `OFS_ABORT) || (paddr == `OFS_INT_STATUS) ||
                  (paddr == `OFS_INT_MASK);
  assign pready  = 1'b1;                  // zero wait states
  assign pslverr = psel && penable && !mapped;

  logic req_wr;     // host request to retrain
  logic reinit_wr;  // host asks for a fresh channel init
  assign req_wr    = wr_acc && (paddr == `OFS_CONTROL) && pwdata[`CTL_RETRAIN_BIT];
  assign reinit_wr = wr_acc && (paddr == `OFS_CONTROL) && pwdata[`CTL_REINIT_BIT];

  // sequencer state
  seq_state_type state_reg, state_next;
  logic [31:0]   alt_cnt_reg, alt_cnt_next;     // cycles of alt seen
  logic [31:0]   tmo_cnt_reg, tmo_cnt_next;     // cycles in this step
  logic [7:0]    tx_code_reg, tx_code_next;
  logic [7:0]    rx_code_reg, rx_code_next;
  logic [7:0]    abort_reg, abort_next;
  logic          cts_reg, cts_next;
  logic          req_pend_reg, req_pend_next;   // request bit, self clearing
  tx_signal_type txs_reg, txs_next;

  // next state: one step per line event, with step timeout
  always_comb begin
    state_next    = state_reg;
    alt_cnt_next  = ev_alt ? alt_cnt_reg + 32'h1 : 32'h0;
    tmo_cnt_next  = tmo_cnt_reg + 32'h1;
    abort_next    = abort_reg;
    req_pend_next = req_pend_reg | req_wr;
    unique case (state_reg)
      ST_INIT:      if (ev_sh) state_next = ST_SH_FOUND;
      ST_SH_FOUND:  state_next = ST_SH_WAIT;
      ST_SH_WAIT: begin
        if (ev_e) state_next = ST_DATA;
        else if (ev_mph2) state_next = ST_E_SEQ;
        else if (ev_alt) state_next = ST_ALT;
      end
      ST_DATA, ST_FAIL: begin
        if (req_pend_reg) begin
          state_next    = ST_AC;
          req_pend_next = 1'b0;
          abort_next    = `ABORT_NONE;
        end
      end
      ST_AC:        if (ev_ac) state_next = ST_AC_FOUND;
      ST_AC_FOUND:  state_next = ST_PPH;
      ST_PPH:       if (ev_pph) state_next = ST_ALT;
      ST_ALT: begin
        // a short burst is a glitch; any length in the window is taken
        if (alt_cnt_reg > ALT_MAX_CYC) begin
          state_next = ST_FAIL;
          abort_next = `ABORT_ALT_LONG;
        end else if (!ev_alt && alt_cnt_reg >= ALT_MIN_CYC) begin
          state_next = ST_ALT_FOUND;
        end
      end
      ST_ALT_FOUND: state_next = ST_MPH;
      ST_MPH:       if (ev_mph2) state_next = ST_E_SEQ;
      ST_E_SEQ:     if (ev_e) state_next = ST_DATA;
    endcase
    if (state_next != state_reg) tmo_cnt_next = 32'h0;
    // stuck step ends in fail; data, init and fail wait forever
    if (state_reg != ST_DATA && state_reg != ST_FAIL && state_reg != ST_INIT &&
        state_next == state_reg && tmo_cnt_reg >= TIMEOUT_CYCLES - 1) begin
      state_next = ST_FAIL;
      abort_next = `ABORT_TIMEOUT;
    end
    if (reinit_wr) begin
      state_next    = ST_INIT;
      req_pend_next = 1'b0;
    end
  end

  // status codes, cts and transmit signal follow the next state
  always_comb begin
    tx_code_next = tx_code_reg;            // fail keeps the last codes
    rx_code_next = rx_code_reg;
    txs_next     = TXS_SILENCE;
    cts_next     = 1'b0;
    unique case (state_next)
      ST_INIT:      begin tx_code_next = `CODE_INIT;    rx_code_next = `CODE_INIT;      end
      ST_SH_FOUND:  begin tx_code_next = `CODE_SH_WAIT; rx_code_next = `CODE_SH_FOUND;
                          txs_next = TXS_SH; end
      ST_SH_WAIT:   begin tx_code_next = `CODE_SH_WAIT; rx_code_next = `CODE_SH_WAIT;
                          txs_next = TXS_SH; end
      ST_DATA:      begin tx_code_next = `CODE_DATA;    rx_code_next = `CODE_DATA;
                          cts_next = 1'b1; end
      ST_AC:        begin tx_code_next = `CODE_AC;      rx_code_next = `CODE_AC;
                          txs_next = TXS_AC; end
      ST_AC_FOUND:  begin tx_code_next = `CODE_AC;      rx_code_next = `CODE_AC_FOUND;
                          txs_next = TXS_AC; end
      ST_PPH:       begin tx_code_next = `CODE_PPH;     rx_code_next = `CODE_AC_FOUND;
                          txs_next = TXS_PPH; end
      ST_ALT:       begin tx_code_next = `CODE_ALT;     rx_code_next = `CODE_ALT;
                          txs_next = TXS_ALT; end
      ST_ALT_FOUND: begin tx_code_next = `CODE_ALT;     rx_code_next = `CODE_ALT_FOUND;
                          txs_next = TXS_ALT; end
      ST_MPH:       begin tx_code_next = `CODE_MPH;     rx_code_next = `CODE_MPH;
                          txs_next = TXS_MPH; end
      ST_E_SEQ:     begin tx_code_next = `CODE_E_SEQ;   rx_code_next = `CODE_E_SEQ;
                          txs_next = TXS_E_SEQ; end
      ST_FAIL:      txs_next = TXS_SILENCE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= ST_INIT;
      alt_cnt_reg  <= 32'h0;
      tmo_cnt_reg  <= 32'h0;
      tx_code_reg  <= `CODE_INIT;
      rx_code_reg  <= `CODE_INIT;
      abort_reg    <= `ABORT_RST;
      cts_reg      <= 1'b0;
      req_pend_reg <= 1'b0;
      txs_reg      <= TXS_SILENCE;
    end else begin
      state_reg    <= state_next;
      alt_cnt_reg  <= alt_cnt_next;
      tmo_cnt_reg  <= tmo_cnt_next;
      tx_code_reg  <= tx_code_next;
      rx_code_reg  <= rx_code_next;
      abort_reg    <= abort_next;
      cts_reg      <= cts_next;
      req_pend_reg <= req_pend_next;
      txs_reg      <= txs_next;
    end
  end

  assign cts       = cts_reg;
  assign tx_signal = txs_reg;

  // interrupt events: completion, abort, any code change
  logic [`INT_WIDTH-1:0] int_sts_reg, int_sts_next;
  logic [`INT_WIDTH-1:0] int_mask_reg, int_mask_next;
  logic [`INT_WIDTH-1:0] int_ev;
  logic [31:0]           prdata_reg, prdata_next;

  always_comb begin
    int_ev = '0;
    int_ev[`INT_DONE_BIT]   = cts_next && !cts_reg;
    int_ev[`INT_ABORT_BIT]  = (state_next == ST_FAIL) && (state_reg != ST_FAIL);
    int_ev[`INT_CHANGE_BIT] = (tx_code_next != tx_code_reg) || (rx_code_next != rx_code_reg);
    int_sts_next = int_sts_reg;
    // read clears only the bits this read reported (latched at setup), so an
    // event landing between the setup and access edges survives; a new event
    // in the clearing cycle wins as well
    if (rd_acc && paddr == `OFS_INT_STATUS) begin
      int_sts_next = int_sts_reg & ~prdata_reg[`INT_WIDTH-1:0];
    end
    int_sts_next  = int_sts_next | int_ev;
    int_mask_next = int_mask_reg;
    if (wr_acc && paddr == `OFS_INT_MASK) int_mask_next = pwdata[`INT_WIDTH-1:0];
    // read data latched in setup so it stands through the access phase
    prdata_next = prdata_reg;
    if (psel && !penable) begin
      prdata_next = 32'h0;
      unique case (paddr)
        `OFS_CONTROL:    prdata_next[`CTL_RETRAIN_BIT] = req_pend_reg;
        `OFS_STATUS: begin
          prdata_next[`STS_CTS_BIT]           = cts_reg;
          prdata_next[`STS_TX_LSB +: 8]       = tx_code_reg;
          prdata_next[`STS_RX_LSB +: 8]       = rx_code_reg;
        end
        `OFS_ABORT:      prdata_next[7:0] = abort_reg;
        `OFS_INT_STATUS: prdata_next[`INT_WIDTH-1:0] = int_sts_reg;
        `OFS_INT_MASK:   prdata_next[`INT_WIDTH-1:0] = int_mask_reg;
        default:         prdata_next = 32'h0;
      endcase
    end
  end

  // bus side registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_sts_reg  <= '0;
      int_mask_reg <= `INT_MASK_RST;
      prdata_reg   <= 32'h0;
    end else begin
      int_sts_reg  <= int_sts_next;
      int_mask_reg <= int_mask_next;
      prdata_reg   <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign irq    = |(int_sts_reg & int_mask_reg);

  // checks
  req_drops_cts_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_DATA && req_pend_reg && !reinit_wr) |=> (!cts && tx_signal == TXS_AC))
    else $error("retrain request did not drop cts and start ac");
  pph_leads_alt_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_PPH && ev_pph && !reinit_wr) |=> (tx_signal == TXS_ALT))
    else $error("pph detect did not move to alt");
  done_raises_cts_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_E_SEQ && ev_e && !reinit_wr) |=> $rose(cts))
    else $error("cts not raised on completion");
  mph_needs_match_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_MPH && !ev_mph2 && !reinit_wr && tmo_cnt_reg < TIMEOUT_CYCLES - 1)
      |=> (tx_signal == TXS_MPH))
    else $error("mph stopped without a match");
  alt_window_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_ALT && state_next == ST_ALT_FOUND)
      |-> (alt_cnt_reg >= ALT_MIN_CYC && alt_cnt_reg <= ALT_MAX_CYC))
    else $error("alt accepted outside its window");
  data_codes_a: assert property (@(posedge clk) disable iff (!rst_n)
    cts |-> (tx_code_reg == `CODE_DATA && rx_code_reg == `CODE_DATA))
    else $error("data mode codes not 84");
  ac_codes_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_signal == TXS_AC) |-> (tx_code_reg == `CODE_AC))
    else $error("ac sent without code 8a");
  fail_holds_codes_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_FAIL && $past(state_reg) == ST_FAIL)
      |-> ($stable(tx_code_reg) && $stable(rx_code_reg) && abort_reg != `ABORT_NONE))
    else $error("fail lost diagnostic codes");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    (|(int_ev & int_mask_next)) |=> irq)
    else $error("unmasked event did not raise irq");

  full_retrain_c: cover property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_AC) ##[1:1000] (state_reg == ST_DATA));
  sh_page_c:      cover property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_SH_WAIT) ##[1:1000] (state_reg == ST_DATA));
  alt_long_c:     cover property (@(posedge clk) disable iff (!rst_n)
    (abort_next == `ABORT_ALT_LONG) && (state_reg == ST_ALT));
  irq_c:          cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));

endmodule : cc_retrain_sequencer

`default_nettype wire

// file: control_channel_retrain_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "retrain_cfg.svh"

module control_channel_retrain_sequencer_tb_top
  import retrain_pkg::*;
();
  localparam int SYM  = 2;     // short symbol keeps alt bursts brief
  localparam int TMO  = 2000;  // short step limit, the real one runs for ages
  localparam int CEIL = 40000; // whole-run cycle ceiling
  logic          clk, rst_n;                 // clock and sync reset
  logic          psel, penable, pwrite;      // apb controls
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, q;          // q holds the last read
  logic          pready, pslverr, e;         // e holds the last error
  logic          ac, pph, alt, mph, edet, sh;// line events from the model
  logic          cts, irq;
  tx_signal_type tx_signal;
  logic [15:0]   resp_delay, alt_len;        // model pacing
  logic          send_sh;
  int            n_mismatch, n_tests;
  int            cycles = 0;                 // watchdog count
  // slow retrain walk: signal sent and the status word it must show
  tx_signal_type steps [5] = '{TXS_AC, TXS_PPH, TXS_ALT, TXS_MPH, TXS_E_SEQ};
  logic [31:0]   codes [5] = '{32'h008A8A00, 32'h00868800, 32'h00818100,
                               32'h00828200, 32'h00838300};

  cc_retrain_sequencer #(.SYMBOL_CYCLES(SYM), .TIMEOUT_CYCLES(TMO)) cc_retrain_sequencer_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ac_detect(ac), .pph_detect(pph), .alt_detect(alt),
    .mph_match(mph), .e_detect(edet), .sh_detect(sh), .cts(cts),
    .tx_signal(tx_signal), .irq(irq)
  );

  remote_modem_model remote_modem_model_i (
    .clk(clk), .rst_n(rst_n), .tx_signal(tx_signal), .resp_delay(resp_delay),
    .alt_len(alt_len), .send_sh(send_sh), .ac_detect(ac), .pph_detect(pph),
    .alt_detect(alt), .mph_match(mph), .e_detect(edet), .sh_detect(sh)
  );

  // 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, q, exp);
    chk({what, " err"}, {31'h0, e}, 32'h0);
  endtask : rchk

  // bounded wait: 0 cts high, 1 irq high, 2 tx_signal equals t
  task automatic wait_for(input int sel, input tx_signal_type t, input string what);
    int n;
    n = 0;
    while (!((sel == 0 && cts === 1'b1) || (sel == 1 && irq === 1'b1) ||
             (sel == 2 && tx_signal === t)) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(what, {31'h0, n < 3000}, 32'h1);
  endtask : wait_for

  // the next edge after the request write must drop cts and start ac
  task automatic request();
    apb(1'b1, `OFS_CONTROL, 32'h1);
    @(posedge clk);
    @(negedge clk);
    chk("cts on request", {31'h0, cts}, 32'h0);
    chk("tx on request", {29'h0, tx_signal}, {29'h0, TXS_AC});
  endtask : request

  initial begin
    {rst_n, psel, penable, pwrite, send_sh} = 5'h00;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    resp_delay = 16'd20;
    alt_len    = 16'd60;
    n_mismatch = 0;
    n_tests    = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk("status", `OFS_STATUS, 32'h00808000);
    rchk("abort", `OFS_ABORT, 32'h0);
    rchk("control", `OFS_CONTROL, 32'h0);
    rchk("int mask", `OFS_INT_MASK, 32'h0);
    rchk("int status", `OFS_INT_STATUS, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    apb(1'b1, `OFS_STATUS, 32'hFFFFFFFF);
    rchk("status ro", `OFS_STATUS, 32'h00808000);
    $display("test reset done");
    // page with no changes: sh, then e into data mode
    send_sh <= 1'b1;
    wait_for(2, TXS_SH, "sh wait");
    rchk("sh wait", `OFS_STATUS, 32'h00898900);
    send_sh <= 1'b0;
    wait_for(0, TXS_SH, "cts page");
    rchk("data", `OFS_STATUS, 32'h00848401);
    $display("test page done");
    // slow remote: every step held long enough to read its codes
    apb(1'b1, `OFS_INT_MASK, 32'h1);
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    resp_delay <= 16'd40;
    alt_len    <= 16'(120 * SYM - 4);
    request();
    for (int i = 0; i < 5; i++) begin
      wait_for(2, steps[i], "step");
      rchk("step code", `OFS_STATUS, codes[i]);
    end
    chk("irq masked", {31'h0, irq}, 32'h0);
    wait_for(0, TXS_AC, "cts slow");
    rchk("data", `OFS_STATUS, 32'h00848401);
    chk("irq done", {31'h0, irq}, 32'h1);
    rchk("int status", `OFS_INT_STATUS, 32'h5);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test slow retrain done");
    // prompt remote, alt 4 cycles over the shortest accepted
    resp_delay <= 16'd1;
    alt_len    <= 16'(16 * SYM + 4);
    request();
    wait_for(0, TXS_AC, "cts prompt");
    rchk("data", `OFS_STATUS, 32'h00848401);
    $display("test prompt retrain done");
    // too short an alt is ignored, so the step times out
    apb(1'b1, `OFS_INT_MASK, 32'h2);
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    resp_delay <= 16'd4;
    alt_len    <= 16'(16 * SYM - 4);
    request();
    wait_for(1, TXS_AC, "abort irq");
    rchk("abort", `OFS_ABORT, 32'h1);
    rchk("kept", `OFS_STATUS, 32'h00818100);
    rchk("int status", `OFS_INT_STATUS, 32'h6);
    @(negedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test short alt done");
    // too long an alt aborts; retrain is honoured from the failed state
    alt_len <= 16'(120 * SYM + 8);
    request();
    wait_for(1, TXS_AC, "abort irq");
    rchk("abort", `OFS_ABORT, 32'h2);
    rchk("kept", `OFS_STATUS, 32'h00818100);
    apb(1'b1, `OFS_CONTROL, 32'h2);
    rchk("reinit", `OFS_STATUS, 32'h00808000);
    $display("test long alt done");
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
endmodule : control_channel_retrain_sequencer_tb_top

`default_nettype wire

// file: line_event_sync.sv
`timescale 1ns/1ps
`default_nettype none

module line_event_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;     // first stage, read only by s2
  logic [WIDTH-1:0] s2_reg;     // second stage
  logic [WIDTH-1:0] s3_reg;     // third stage
  logic [WIDTH-1:0] out_reg;    // accepted level
  logic [WIDTH-1:0] out_next;

  // per bit: a change counts once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  // plain shift chain; a glitch seen by one stage only never reaches out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule : line_event_sync

`default_nettype wire

// file: remote_modem_model.sv
`timescale 1ns/1ps
`default_nettype none

// far-end modem: answers each signal the block sends after a set delay
module remote_modem_model
  import retrain_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire tx_signal_type tx_signal,   // signal the block is sending
  input  wire logic [15:0]   resp_delay,  // cycles before we answer
  input  wire logic [15:0]   alt_len,     // alt burst length in cycles
  input  wire logic          send_sh,     // page path: line carries sh
  output logic               ac_detect,
  output logic               pph_detect,
  output logic               alt_detect,
  output logic               mph_match,
  output logic               e_detect,
  output logic               sh_detect
);
  tx_signal_type last_reg, last_next;     // signal seen last cycle
  logic [15:0]   age_reg, age_next;       // cycles since it changed
  logic          ready;                   // answer delay has run out

  // age restarts on every change and saturates instead of wrapping
  always_comb begin
    last_next = tx_signal;
    age_next  = (tx_signal != last_reg) ? 16'h0000 : ((&age_reg) ? age_reg : age_reg + 16'h0001);
  end

  // state registers only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_reg <= TXS_SILENCE;
      age_reg  <= 16'h0000;
    end else begin
      last_reg <= last_next;
      age_reg  <= age_next;
    end
  end

  // answers are levels held until the block moves on, alt only for alt_len cycles; never early
  always_comb begin
    ready      = (tx_signal == last_reg) && (age_reg >= resp_delay);
    ac_detect  = ready && (tx_signal == TXS_AC);
    pph_detect = ready && (tx_signal == TXS_PPH);
    alt_detect = ready && (tx_signal == TXS_ALT) &&
                 ({1'b0, age_reg} < {1'b0, resp_delay} + {1'b0, alt_len});
    mph_match  = ready && (tx_signal == TXS_MPH);
    e_detect   = ready && (tx_signal == TXS_E_SEQ || tx_signal == TXS_SH);
    sh_detect  = send_sh;
  end
endmodule : remote_modem_model

`default_nettype wire

// file: retrain_cfg.svh
`ifndef RETRAIN_CFG_SVH
`define RETRAIN_CFG_SVH

// apb register byte offsets
`define OFS_CONTROL     12'h000
`define OFS_STATUS      12'h004
`define OFS_ABORT       12'h008
`define OFS_INT_STATUS  12'h00C
`define OFS_INT_MASK    12'h010

// control register fields
`define CTL_RETRAIN_BIT 0
`define CTL_REINIT_BIT  1

// status register fields
`define STS_CTS_BIT     0
`define STS_TX_LSB      8
`define STS_RX_LSB      16

// interrupt bit positions
`define INT_DONE_BIT    0
`define INT_ABORT_BIT   1
`define INT_CHANGE_BIT  2
`define INT_WIDTH       3

// reset values
`define INT_MASK_RST    3'h0
`define ABORT_RST       8'h00

// handshake status codes, control channel phase
`define CODE_INIT       8'h80
`define CODE_ALT        8'h81
`define CODE_MPH        8'h82
`define CODE_E_SEQ      8'h83
`define CODE_DATA       8'h84
`define CODE_AC_FOUND   8'h86
`define CODE_SH_FOUND   8'h87
`define CODE_PPH        8'h88
`define CODE_SH_WAIT    8'h89
`define CODE_AC         8'h8A
`define CODE_ALT_FOUND  8'h8B

// abort reasons
`define ABORT_NONE      8'h00
`define ABORT_TIMEOUT   8'h01
`define ABORT_ALT_LONG  8'h02

// timing: alt length limits in symbols, supervision time in ms
`define ALT_MIN_SYM     16
`define ALT_MAX_SYM     120
`define STEP_TIMEOUT_MS 2000
`define CLK_KHZ         50000
`define STEP_TIMEOUT_CYC (`STEP_TIMEOUT_MS * `CLK_KHZ)

`endif

// file: retrain_pkg.sv
`default_nettype none

package retrain_pkg;

  // sequencer states of the control channel
  typedef enum logic [3:0] {
    ST_INIT, ST_SH_FOUND, ST_SH_WAIT, ST_DATA, ST_AC, ST_AC_FOUND,
    ST_PPH, ST_ALT, ST_ALT_FOUND, ST_MPH, ST_E_SEQ, ST_FAIL
  } seq_state_type;

  // signal the transmitter is told to send
  typedef enum logic [2:0] {
    TXS_SILENCE, TXS_AC, TXS_PPH, TXS_ALT, TXS_MPH, TXS_E_SEQ, TXS_SH
  } tx_signal_type;

endpackage : retrain_pkg

`default_nettype wire
